// file: core/tvpa_core.sv
// TDM voice packet assembly with phasing counters and low-latency loopback
//
// Operation
// - Up to 128 loop links; looped bytes leave on receive slots with same number
// - Per-channel buffer; packet emitted once pending bytes reach the packet length
// - PCM 64k, ADPCM 40/32/24/16k captures 5/4/3/2 bits of each byte
// - One global MSB or LSB choice for all compressed samples
// - Coding unit is 8 blocks; packets of 1,2,3,4,5 or 8 units
// - 40-byte and 44-byte packets form the 40/80 and 44/88 modes
// - Single-slot format: one slot per sample, no encoding indication
// - ADPCM byte carries nibble, a one and zero padding; rate implicit
// - One encoding per packet; rate changes only at packet boundaries
// - Dual-slot format carries explicit PCM or ADPCM indication
// - Dual-slot: flag in, sample in, reset flag out, sample out
// - With silence suppression, reset decompressor before talk after silence
// - Dual-slot reset flag field is 11 on voice after padding
// - Eight quads of four streams; format chosen by control bits 13:6
// - Packets repeat every 8 times coding unit count frames
// - One phase counter per unit count above 1, wrapping at 1,2,3,4,7,9,10
// - Sub-phase counts 0 to 7 per frame; phases step on its wrap
// - Packet cut when phase and sub-phase equal channel's programmed values
// - Counters free run from an arbitrary frame by default
// - Phasing slot byte loads counters each frame: 00h phase 0 sub-phase 0
// - Four pattern selects 0-23, 0-79, 0-63, 0-87; upper bits truncated
// - Slots identified by slot-stream number per stream rate
// - Map entries are voice, HDLC, loopback or phasing
`timescale 1ns/1ps
`default_nettype none
module tvpa_core #(
    parameter int NSLOT     = 32,
    parameter int STREAM_ID = 0,
    parameter int RATE_SEL  = 2
) (
    // System
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // TDM link
    input  wire logic                  tdm_clk,
    input  wire logic                  tdm_fs,
    input  wire logic                  tdm_din,
    output logic                       tdm_dout,
    output logic                       tdm_oe,
    // Assembled bytes and packet cuts
    output logic                       asm_valid,
    output tvpa_pkg::tvpa_asm_type     asm_out,
    output logic                       pkt_valid,
    output tvpa_pkg::tvpa_pkt_type     pkt_out
);
    import tvpa_pkg::*;

    localparam int SW = $clog2(NSLOT);

    // Parameter sanity
    if (NSLOT < 4 || NSLOT > 64 || NSLOT % 4 != 0 || STREAM_ID > 31 || RATE_SEL > 2) begin : g_bad
        $error("tvpa_core: unsupported parameter values");
    end

    // Register file and slot state
    logic [MAP_W-1:0] map_r [NSLOT];
    logic [RXM_W-1:0] rxm_r [NSLOT];
    logic [31:0]      ctrl_r;
    logic [7:0]       lll_mem [NLOOP];
    logic [15:0]      acc_r [NSLOT];
    logic [3:0]       nbit_r [NSLOT];
    logic [7:0]       pend_r [NSLOT];
    logic [2:0]       enc_r [NSLOT];
    logic             sil_r [NSLOT];
    logic             rstp_r [NSLOT];
    logic             fpcm_r [NSLOT];
    logic [3:0]       ph_r [NPH];
    logic [2:0]       sub_r;
    logic             started_r;

    // Link synchronisers {clk, fs, din} and edge history
    logic [2:0] lk1_r, lk2_r, lk3_r;
    logic [2:0] bit_r;
    logic [SW-1:0] slot_r, bslot_r;
    logic [7:0] sh_r, byte_r;
    logic byte_ev_r;
    logic dout_r, oe_r;

    // Link edges and frame marker
    wire rise  = lk2_r[2] & ~lk3_r[2];
    wire fall  = ~lk2_r[2] & lk3_r[2];
    wire fs_in = lk2_r[1];
    wire d_in  = lk2_r[0];
    wire tick  = rise & fs_in & started_r;

    // Quad format of this stream
    wire dual = ctrl_r[CTRL_QUAD + STREAM_ID / 4];

    always_ff @(posedge ref_clk) begin
        lk1_r <= {tdm_clk, tdm_fs, tdm_din};
        lk2_r <= lk1_r;
        lk3_r <= lk2_r;
    end

    // Bit and slot counting, byte assembly
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bit_r     <= 3'h0;
            slot_r    <= '0;
            bslot_r   <= '0;
            sh_r      <= 8'h00;
            byte_r    <= 8'h00;
            byte_ev_r <= 1'b0;
            started_r <= 1'b0;
        end else begin
            byte_ev_r <= rise & (fs_in ? 1'b0 : bit_r == 3'h7);
            if (rise) begin
                sh_r <= {sh_r[6:0], d_in};
                if (fs_in) begin
                    bit_r     <= 3'h1;
                    slot_r    <= '0;
                    started_r <= 1'b1;
                end else begin
                    bit_r <= bit_r + 3'h1;
                    if (bit_r == 3'h7) begin
                        byte_r  <= {sh_r[6:0], d_in};
                        bslot_r <= slot_r;
                        slot_r  <= (slot_r == SW'(NSLOT - 1)) ? '0 : slot_r + 1'b1;
                    end
                end
            end
        end
    end

    // Current byte decode
    wire [MAP_W-1:0] m   = map_r[bslot_r];
    wire [1:0]  m_type   = m[M_TYPE +: 2];
    wire [2:0]  m_cu     = m[M_CU +: 3];
    wire [1:0]  pos      = bslot_r[1:0];
    wire        is_voice = byte_ev_r & (m_type == CH_VOICE);
    wire        is_flag  = is_voice & dual & (pos == 2'b00);
    wire        is_samp  = is_voice & (~dual | (pos == 2'b01));
    wire        is_rfl   = byte_ev_r & dual & (pos == 2'b10);
    wire        is_loop  = byte_ev_r & (m_type == CH_LOOP);
    wire        is_phase = byte_ev_r & (m_type == CH_PHASE);

    // Sample extraction and packing
    wire [2:0]  enc_a   = enc_r[bslot_r];
    wire [3:0]  nb      = bits_of(enc_a);
    wire [7:0]  msk     = 8'hFF >> (4'h8 - nb);
    wire [7:0]  blk_lsb = byte_r & msk;
    wire [7:0]  blk_msb = byte_r >> (4'h8 - nb);
    wire [7:0]  blk     = ctrl_r[CTRL_LSB] ? blk_lsb : blk_msb;
    wire [15:0] acc_n   = (acc_r[bslot_r] << nb) | {8'h00, blk};
    wire [3:0]  nbit_s  = nbit_r[bslot_r] + nb;
    wire        emit    = is_samp & (nbit_s >= 4'h8);
    wire [3:0]  nbit_n  = emit ? nbit_s - 4'h8 : nbit_s;
    wire [7:0]  ebyte   = 8'(acc_n >> nbit_n);
    wire [7:0]  pend_a  = pend_r[bslot_r] + {7'h00, emit};

    // Packet length from coding unit count and rate
    wire [7:0]  units   = 8'(CU_UNITS[m_cu]);
    wire [7:0]  len_var = 8'(units * {4'h0, nb});
    wire [7:0]  len_fix = (m_cu == CU_4080) ? LEN_4080 : LEN_4488;
    wire [7:0]  plen    = (m_cu >= CU_4080) ? len_fix : len_var;

    // Phase match for this channel
    wire [3:0]  ph_cur  = (m_cu == 3'h0) ? 4'h0 : ph_r[m_cu - 3'h1];
    wire        ph_ok   = (ph_cur == m[M_PH +: 4]) & (sub_r == m[M_SUB +: 3]);
    wire        cut     = is_samp & ph_ok & (pend_a >= plen);
    wire        now_sil = m[M_SIL];
    wire        dres    = ctrl_r[CTRL_SSUP] & sil_r[bslot_r] & ~now_sil;
    wire [2:0]  enc_nx  = (dual & fpcm_r[bslot_r]) ? 3'h0 : m[M_ENC +: 3];

    // Slot-stream number of the current byte
    wire [11:0] slot_stream_id = 12'((int'(bslot_r) * TS_MUL[RATE_SEL] + TS_OFF[RATE_SEL])
                           * TS_STREAMS + STREAM_ID);

    // Per-channel accumulation state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NSLOT; i++) begin
                acc_r[i]  <= 16'h0000;
                nbit_r[i] <= 4'h0;
                pend_r[i] <= 8'h00;
                enc_r[i]  <= 3'h0;
                sil_r[i]  <= 1'b0;
                fpcm_r[i] <= 1'b0;
                rstp_r[i] <= 1'b0;
            end
        end else begin
            if (is_flag)
                fpcm_r[bslot_r] <= byte_r[7];
            if (is_samp) begin
                acc_r[bslot_r]  <= acc_n;
                nbit_r[bslot_r] <= nbit_n;
                pend_r[bslot_r] <= cut ? pend_a - plen : pend_a;
            end
            if (cut) begin
                enc_r[bslot_r] <= enc_nx;
                sil_r[bslot_r] <= now_sil;
                nbit_r[bslot_r] <= 4'h0;
            end
            if (is_rfl)
                rstp_r[bslot_r - 1'b1] <= 1'b0;
            if (cut & dres & dual)
                rstp_r[bslot_r] <= 1'b1;
        end
    end

    // Assembled byte and packet outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            asm_valid <= 1'b0;
            asm_out   <= '0;
            pkt_valid <= 1'b0;
            pkt_out   <= '0;
        end else begin
            asm_valid <= emit;
            pkt_valid <= cut;
            if (emit)
                asm_out <= '{chan: 6'(bslot_r), data: ebyte};
            if (cut)
                pkt_out <= '{chan: 6'(bslot_r), slot_stream_id: slot_stream_id, len: plen, dreset: dres};
        end
    end

    // Phasing loads per pattern select
    wire [1:0] pps = m[M_PPS +: 2];

    // Phase and sub-phase counters
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sub_r <= 3'h0;
            for (int i = 0; i < NPH; i++)
                ph_r[i] <= 4'h0;
        end else if (is_phase) begin
            sub_r <= byte_r[2:0];
            unique case (pps)
                2'b00: ph_r[1] <= {2'h0, byte_r[4:3]};
                2'b01: begin
                    ph_r[3] <= {1'b0, byte_r[5:3]};
                    ph_r[5] <= byte_r[6:3];
                end
                2'b10: begin
                    ph_r[0] <= {3'h0, byte_r[3]};
                    ph_r[2] <= {2'h0, byte_r[4:3]};
                    ph_r[4] <= {1'b0, byte_r[5:3]};
                end
                2'b11: ph_r[6] <= byte_r[6:3];
            endcase
        end else if (tick) begin
            sub_r <= sub_r + 3'h1;
            if (sub_r == SUB_MAX)
                for (int i = 0; i < NPH; i++)
                    ph_r[i] <= (ph_r[i] >= PH_MAX[i]) ? 4'h0 : ph_r[i] + 4'h1;
        end
    end

    // Loop memory fill from looped transmit slots
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NLOOP; i++)
                lll_mem[i] <= 8'h00;
        end else if (is_loop) begin
            lll_mem[m[M_LOOP +: 7]] <= byte_r;
        end
    end

    // Receive-side byte for the slot now on the wire
    wire [RXM_W-1:0] rx   = rxm_r[slot_r];
    wire             o_rf = dual & (slot_r[1:0] == 2'b10);
    wire             o_lp = rx[RXM_EN] & ~(dual & ~slot_r[1]);
    wire             o_rs = rstp_r[(slot_r & ~SW'(3)) | SW'(1)];  // Sample slot of this quad
    wire [7:0]       o_fl = {o_rs ? RST_FLAG : 2'b00, 6'h00};
    wire [7:0]       obyte = o_rf ? o_fl : lll_mem[rx[6:0]];
    wire             odrv  = started_r & (o_rf | o_lp);

    // Drive receive data on falling link edges
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dout_r <= 1'b0;
            oe_r   <= 1'b0;
        end else if (fall) begin
            dout_r <= obyte[3'h7 - bit_r];
            oe_r   <= odrv;
        end
    end

    assign tdm_dout = dout_r;
    assign tdm_oe   = oe_r;

    // AHB-Lite address decode
    wire        a_take = hsel & hready & htrans[1];
    wire        a_low  = (haddr[31:12] == 20'h00000);
    wire [5:0]  a_idx  = haddr[7:2];
    wire        a_in   = ({26'h0, a_idx} < 32'(NSLOT));
    wire        h_map  = a_low & a_in & (haddr[11:8] == MAP_BASE[11:8]);
    wire        h_rxm  = a_low & a_in & (haddr[11:8] == RXM_BASE[11:8]);
    wire        h_ctl  = a_low & (haddr[11:0] == CTRL_OFS);
    wire        h_sta  = a_low & (haddr[11:0] == STAT_OFS);
    wire [31:0] stat   = {20'h0, ph_r[6], 4'(started_r), 1'b0, sub_r};
    wire [31:0] rd_map = 32'(map_r[a_idx[SW-1:0]]);
    wire [31:0] rd_rxm = 32'(rxm_r[a_idx[SW-1:0]]);
    wire [31:0] rd_w   = h_map ? rd_map : h_rxm ? rd_rxm :
                         h_ctl ? ctrl_r : h_sta ? stat : 32'h0;

    // AHB data phase state
    logic          wmap_r, wrxm_r, wctl_r;
    logic [SW-1:0] widx_r;
    logic [31:0]   hrdata_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wmap_r   <= 1'b0;
            wrxm_r   <= 1'b0;
            wctl_r   <= 1'b0;
            widx_r   <= '0;
            hrdata_r <= 32'h0;
        end else begin
            wmap_r <= a_take & hwrite & h_map;
            wrxm_r <= a_take & hwrite & h_rxm;
            wctl_r <= a_take & hwrite & h_ctl;
            if (a_take)
                widx_r <= a_idx[SW-1:0];
            if (a_take & ~hwrite)
                hrdata_r <= rd_w;
        end
    end

    // Register writes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
            for (int i = 0; i < NSLOT; i++) begin
                map_r[i] <= '0;
                rxm_r[i] <= '0;
            end
        end else begin
            if (wctl_r)
                ctrl_r <= hwdata;
            if (wmap_r)
                map_r[widx_r] <= hwdata[MAP_W-1:0];
            if (wrxm_r)
                rxm_r[widx_r] <= hwdata[RXM_W-1:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
endmodule
`default_nettype wire

// file: core/tvpa_pkg.sv
// Shared constants and types for the TDM voice packet assembly block
package tvpa_pkg;
    // Register byte offsets
    localparam logic [11:0] MAP_BASE = 12'h400;
    localparam logic [11:0] RXM_BASE = 12'h600;
    localparam logic [11:0] CTRL_OFS = 12'h700;
    localparam logic [11:0] STAT_OFS = 12'h704;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // Control register fields
    localparam int CTRL_LSB  = 0;
    localparam int CTRL_SSUP = 1;
    localparam int CTRL_QUAD = 6;
    // Transmit channel map entry fields
    localparam int M_TYPE = 0;
    localparam int M_CU   = 2;
    localparam int M_ENC  = 5;
    localparam int M_PH   = 8;
    localparam int M_SUB  = 12;
    localparam int M_PPS  = 16;
    localparam int M_LOOP = 18;
    localparam int M_SIL  = 25;
    localparam int MAP_W  = 26;
    // Receive channel map entry: enable and loop number
    localparam int RXM_EN = 7;
    localparam int RXM_W  = 8;
    // Loop memory size, phase counters and sub-phase range
    localparam int NLOOP = 128;
    localparam int NPH   = 7;
    localparam logic [3:0] PH_MAX [NPH] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h9, 4'hA};
    localparam logic [2:0] SUB_MAX = 3'h7;
    // Coding units per count code, fixed lengths for 40/80 and 44/88
    localparam int CU_UNITS [8] = '{1, 2, 3, 4, 5, 8, 10, 11};
    localparam logic [7:0] LEN_4080 = 8'h28;
    localparam logic [7:0] LEN_4488 = 8'h2C;
    localparam logic [2:0] CU_4080 = 3'h6;
    localparam logic [2:0] CU_4488 = 3'h7;
    // Dual-slot receive reset flag value
    localparam logic [1:0] RST_FLAG = 2'b11;
    // Slot-stream numbering: (slot*mul+off)*32+stream per rate code
    localparam int TS_MUL [3] = '{1, 2, 4};
    localparam int TS_OFF [3] = '{0, 1, 3};
    localparam int TS_STREAMS = 32;

    typedef enum logic [1:0] {
        CH_VOICE = 2'b00,
        CH_HDLC  = 2'b01,
        CH_LOOP  = 2'b10,
        CH_PHASE = 2'b11
    } tvpa_ch_type;

    typedef struct packed {
        logic [5:0]  chan;
        logic [11:0] slot_stream_id;
        logic [7:0]  len;
        logic        dreset;
    } tvpa_pkt_type;

    typedef struct packed {
        logic [5:0] chan;
        logic [7:0] data;
    } tvpa_asm_type;

    // Bits captured per sample: PCM 8, ADPCM 40/32/24/16k
    function automatic logic [3:0] bits_of(input logic [2:0] enc);
        case (enc)
            3'h1:    bits_of = 4'h5;
            3'h2:    bits_of = 4'h4;
            3'h3:    bits_of = 4'h3;
            3'h4:    bits_of = 4'h2;
            default: bits_of = 4'h8;
        endcase
    endfunction
endpackage

// file: tb/tvpa_chk.sv
// Port-level assertions for the TDM voice packet assembly block
`timescale 1ns/1ps
`default_nettype none
module tvpa_chk #(
    parameter int STREAM_ID = 0,
    parameter int RATE_SEL  = 2
) (
    // System and bus
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic                   hready,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire logic [31:0]            hrdata,
    // Link and results
    input wire logic                   tdm_oe,
    input wire logic                   asm_valid,
    input wire logic                   pkt_valid,
    input wire tvpa_pkg::tvpa_pkt_type pkt_out
);
    import tvpa_pkg::*;
    logic        rd_take;
    logic [11:0] slot_stream_id_exp;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Read request taken, expected slot-stream number of a cut
    assign rd_take  = hsel && hready && htrans[1] && !hwrite;
    assign slot_stream_id_exp = 12'((int'(pkt_out.chan) * TS_MUL[RATE_SEL] + TS_OFF[RATE_SEL])
                      * TS_STREAMS + STREAM_ID);
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_asm_pulse: assert property (asm_valid |=> !asm_valid) else $error("asm long");
    a_pkt_pulse: assert property (pkt_valid |=> !pkt_valid) else $error("pkt long");
    a_rst_quiet: assert property ($rose(rst_n) |-> !tdm_oe && !pkt_valid
        && hrdata == 32'h0) else $error("outputs not cleared by reset");
    a_pkt_slot_stream_id: assert property (pkt_valid |-> pkt_out.slot_stream_id == slot_stream_id_exp)
        else $error("slot-stream number wrong");
    a_pkt_len: assert property (pkt_valid |-> pkt_out.len inside {[8'h02:8'h40]})
        else $error("packet length out of range");
    a_rd_hold: assert property (!$past(rd_take) |-> $stable(hrdata))
        else $error("read data moved");
    a_hole_zero: assert property (rd_take && haddr == 32'h0000_07F0 |=> hrdata == 32'h0)
        else $error("hole read not zero");
    // Main scenarios
    c_asm: cover property (asm_valid);
    c_dreset: cover property (pkt_valid && pkt_out.dreset);
    c_read: cover property (rd_take);
endmodule

bind tvpa_core tvpa_chk #(.STREAM_ID(STREAM_ID), .RATE_SEL(RATE_SEL)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tdm_oe(tdm_oe), .asm_valid(asm_valid), .pkt_valid(pkt_valid),
    .pkt_out(pkt_out)
);
`default_nettype wire

// file: tb/tvpa_core_tb_top.sv
// Self-checking bench for the TDM voice packet assembly block
`timescale 1ns/1ps
`default_nettype none
module tvpa_core_tb_top;
    import tvpa_pkg::*;
    logic ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, run, frame_tick;
    logic tdm_clk, tdm_fs, tdm_din, tdm_dout, tdm_oe, asm_valid, pkt_valid;
    logic [31:0] haddr, hwdata, hrdata, tx_bytes, rx_bytes, v, v2;
    logic [1:0] htrans;
    logic [2:0] hsize;
    tvpa_asm_type asm_out, got_a;
    tvpa_pkt_type pkt_out, got_p;
    int fail_count, total_checks;
    assign hready = hreadyout;
    tvpa_core #(.NSLOT(4)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tdm_clk(tdm_clk),
        .tdm_fs(tdm_fs), .tdm_din(tdm_din), .tdm_dout(tdm_dout), .tdm_oe(tdm_oe),
        .asm_valid(asm_valid), .asm_out(asm_out), .pkt_valid(pkt_valid), .pkt_out(pkt_out));
    tvpa_tdm_model #(.NSLOT(4)) u_bus (
        .run(run), .tx_bytes(tx_bytes), .rx_bytes(rx_bytes), .frame_tick(frame_tick),
        .tdm_clk(tdm_clk), .tdm_fs(tdm_fs), .tdm_din(tdm_din), .tdm_dout(tdm_dout),
        .tdm_oe(tdm_oe));
    // Compare and count
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Bounded wait: 0 byte of slot 3, 1 packet of slot 3, 2 frame end
    task automatic wait_ev(input int kind, input int cnt);
        int n;
        logic t;
        for (int i = 0; i < cnt; i++) begin
            n = 0;
            t = frame_tick;
            do begin
                @(posedge ref_clk);
                n++;
            end while (!(kind == 0 ? asm_valid === 1'b1 && asm_out.chan === 6'h3 :
                         kind == 1 ? pkt_valid === 1'b1 && pkt_out.chan === 6'h3 :
                         frame_tick !== t) && n < 30000);
            got_a = asm_out;
            got_p = pkt_out;
            if (n >= 30000) begin
                fail_count++;
                end_of_test();
            end
        end
    endtask
    // Bus phases held until hready is seen high
    task automatic to_ready;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (n >= 100) begin
            fail_count++;
            end_of_test();
        end
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        to_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        to_ready();
        r = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        check(nm, e, r);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {rst_n, hsel, hwrite, run, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        tx_bytes = 32'h5A00_00C5;
        fail_count = 0;
        total_checks = 0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Reset values, control field, unmapped hole
        rd_chk("ctrl", CTRL_OFS, CTRL_RST);
        rd_chk("status", STAT_OFS, 32'h0);
        wr(CTRL_OFS, 32'h0000_3FC3);
        rd_chk("ctrl", CTRL_OFS, 32'h0000_3FC3);
        wr(12'h7F0, 32'hFFFF_FFFF);
        rd_chk("hole", 12'h7F0, 32'h0);
        wr(CTRL_OFS, 32'h0);
        $display("test registers done");
        // Sub-phase steps once per frame after start
        wr(MAP_BASE + 12'h4, 32'h1);
        wr(MAP_BASE + 12'h8, 32'h1);
        run <= 1'b1;
        wait_ev(2, 3);
        ahb(1'b0, STAT_OFS, 32'h0, v);
        wait_ev(2, 1);
        ahb(1'b0, STAT_OFS, 32'h0, v2);
        check("subphase", {29'h0, v[2:0] + 3'h1}, {29'h0, v2[2:0]});
        check("started", 32'h1, {31'h0, v2[4]});
        // Phasing slot, pattern 11, top bit dropped
        wr(MAP_BASE + 12'h4, 32'h0003_0003);
        tx_bytes <= 32'h5A00_ABC5;
        wait_ev(2, 3);
        ahb(1'b0, STAT_OFS, 32'h0, v);
        check("ph_sub", 32'h3, {29'h0, v[2:0]});
        check("ph_4488", 32'h5, {28'h0, v[11:8]});
        wr(MAP_BASE + 12'h4, 32'h1);
        // Loop link 127 from slot 0 out on slot 2
        wr(MAP_BASE, 32'h01FC_0002);
        wr(RXM_BASE + 12'h8, 32'h0000_00FF);
        wait_ev(2, 3);
        check("loop", 32'hC5, {24'h0, rx_bytes[23:16]});
        $display("test phasing and loop done");
        // Packet lengths per encoding, then two units of PCM
        wr(MAP_BASE + 12'hC, 32'h0);
        wait_ev(0, 2);
        check("pcm", 32'h5A, {24'h0, got_a.data});
        for (int i = 0; i < 6; i++) begin
            wr(MAP_BASE + 12'hC, i < 5 ? 32'(i) << 5 : 32'h4);
            wait_ev(1, 2);
            check("len", i == 5 ? 16 : i == 0 ? 8 : 6 - i, {24'h0, got_p.len});
        end
        // Compressed nibble from high or low bits
        wr(MAP_BASE + 12'hC, 32'h40);
        // New rate applies only after the next cut
        wait_ev(1, 1);
        wait_ev(0, 1);
        check("msb", 32'h55, {24'h0, got_a.data});
        wr(CTRL_OFS, 32'h1);
        wait_ev(0, 3);
        check("lsb", 32'hAA, {24'h0, got_a.data});
        // Talk after silence needs a decompressor reset
        wr(CTRL_OFS, 32'h2);
        wr(MAP_BASE + 12'hC, 32'h0200_0000);
        wait_ev(1, 2);
        wr(MAP_BASE + 12'hC, 32'h0);
        wait_ev(1, 1);
        check("dreset", 32'h1, {31'h0, got_p.dreset});
        wait_ev(1, 1);
        check("dreset", 32'h0, {31'h0, got_p.dreset});
        // Quad 0 dual-slot: slot 2 now carries the reset flag byte, not loop data
        wr(CTRL_OFS, 32'h40);
        wait_ev(2, 2);
        check("dual_flag", 32'h0, {24'h0, rx_bytes[23:16]});
        $display("test packets done");
        end_of_test();
    end
endmodule
`default_nettype wire

// file: tb/tvpa_tdm_model.sv
// Behavioural TDM bus: sends slot bytes, captures bytes driven back
`timescale 1ns/1ps
`default_nettype none
module tvpa_tdm_model #(
    parameter int NSLOT = 4
) (
    // Control and slot contents
    input wire logic               run,
    input wire logic [8*NSLOT-1:0] tx_bytes,
    output logic [8*NSLOT-1:0]     rx_bytes,
    output logic                   frame_tick,
    // Link pins
    output logic                   tdm_clk,
    output logic                   tdm_fs,
    output logic                   tdm_din,
    input wire logic               tdm_dout,
    input wire logic               tdm_oe
);
    logic [7:0] sh;
    // Frames back to back, bit7 first, sync on first bit of slot 0
    initial begin
        tdm_clk = 1'b0;
        tdm_fs = 1'b0;
        tdm_din = 1'b0;
        rx_bytes = '0;
        frame_tick = 1'b0;
        sh = 8'h00;
        wait (run);
        forever begin
            for (int s = 0; s < NSLOT; s++) begin
                for (int b = 7; b >= 0; b--) begin
                    tdm_din = tx_bytes[8*s+b];
                    tdm_fs = (s == 0 && b == 7);
                    #40 tdm_clk = 1'b1;
                    sh[b] = tdm_oe ? tdm_dout : ~sh[b];
                    #40 tdm_clk = 1'b0;
                end
                rx_bytes[8*s+:8] = sh;
            end
            frame_tick = ~frame_tick;
        end
    end
endmodule
`default_nettype wire
